// ### atsm_defines.svh
// Constants for the aux temperature and self-test monitor
// Function
// [RULE1] Charge pump off during whole scan
// [RULE2] Host keeps settle delay short under load
// [RULE3] Aux after powerup, cells, self-test; one then two
// [RULE4] Aux results stored at 0x40 and 0x41
// [RULE5] Aux results are 12-bit codes
// [RULE6] Aux phase within 10us or 17us
// [RULE7] Compare each stored result to thresholds
// [RULE8] Violation sets enabled hot/cold status flag
// [RULE9] Per-channel hot/cold enables in result registers
// [RULE10] Flags clear when condition clears
// [RULE11] Alarm pin only with matching alarm enable
// [RULE12] Self-test only when enabled; stored
// [RULE13] Self-test right after cells, before aux
// [RULE14] Self-test data in upper three nibbles
// [RULE15] Host treats about 0x5e1 as normal
// [RULE16] Host decodes short and open codes
// [RULE17] Host tracks self-test baseline drift
// [RULE18] Oscillating reference sets reference-open flag
// [RULE19] Aux converted only when enabled
// [RULE20] Host starts scan via scan bit
// [RULE21] Thermistor bias on at scan start
// [RULE22] Settling delay 5.3us steps before each aux
// [RULE23] Any enabled channel violation sets shared flag
// [RULE24] Alarm holds while routed flag stays set
`ifndef ATSM_DEFINES_SVH
`define ATSM_DEFINES_SVH
`define ATSM_ADDR_STATUS    8'h02
`define ATSM_ADDR_CONVCFG   8'h08
`define ATSM_ADDR_ACQUISITION_CONFIG_REG    8'h0c
`define ATSM_ADDR_SCAN_CONTROL_REG  8'h0d
`define ATSM_ADDR_FAULT     8'h0e
`define ATSM_ADDR_COLD      8'h1e
`define ATSM_ADDR_HOT       8'h1f
`define ATSM_ADDR_AUX1      8'h40
`define ATSM_ADDR_AUX2      8'h41
`define ATSM_ADDR_SELFTEST  8'h42
`define ATSM_ST_HOT         1
`define ATSM_ST_COLD        0
`define ATSM_CFG_AUX1EN     0
`define ATSM_CFG_AUX2EN     1
`define ATSM_CFG_OTEN       2
`define ATSM_CFG_UTEN       3
`define ATSM_CFG_STEN       4
`define ATSM_RES_HOT_COMPARE_ENABLE      15
`define ATSM_RES_COLD_COMPARE_ENABLE     14
`define ATSM_FLT_REFOPEN    0
`define ATSM_STATUS_RST     16'h0000
`define ATSM_CLK_NS         50
`define ATSM_STEP_NS        5300
`define ATSM_STEP_CYC       ((`ATSM_STEP_NS + `ATSM_CLK_NS - 1) / `ATSM_CLK_NS)
`define ATSM_CONV_CYC       8'h28
`define ATSM_PWRUP_CYC      8'h10
`define ATSM_CELL_CYC       8'h40
`define ATSM_REF_TOGGLES    4'h8
`endif

// ### atsm_pkg.sv
// Types for the aux temperature and self-test monitor
package atsm_pkg;
   typedef enum logic [7:0] {
      ATSM_IDLE   = 8'h01,
      ATSM_PWRUP  = 8'h02,
      ATSM_CELLS  = 8'h04,
      ATSM_SELF   = 8'h08,
      ATSM_SET1   = 8'h10,
      ATSM_CONV1  = 8'h20,
      ATSM_SET2   = 8'h40,
      ATSM_CONV2  = 8'h80
   } atsm_state_e;
endpackage

// ### atsm_cmp_if.sv
// Carrier for one aux channel compare
interface atsm_cmp_if;
   logic        stb;
   logic [11:0] code;
   logic [11:0] cold;
   logic [11:0] hot;
   logic        hot_en;
   logic        cold_en;
   logic        hot_v;
   logic        cold_v;
   logic        upd;
   modport ctl (output stb, code, cold, hot, hot_en, cold_en, input hot_v, cold_v, upd);
   modport cmp (input stb, code, cold, hot, hot_en, cold_en, output hot_v, cold_v, upd);
endinterface

// ### atsm_cmp.sv
// Per-channel threshold compare with registered verdicts
`include "atsm_defines.svh"
module atsm_cmp (
   input wire logic pclk,
   input wire logic presetn,
   atsm_cmp_if.cmp  c
);
   typedef struct packed {
      logic hot_v;
      logic cold_v;
      logic upd;
   } atsm_cmp_s;
   atsm_cmp_s r, next_r;

   // Verdict recomputed only when a new result is stored
   always_comb begin
      next_r = r;
      next_r.upd = c.stb;
      if (c.stb) begin
         next_r.hot_v  = c.hot_en && (c.code > c.hot);   // [RULE7] [RULE9]
         next_r.cold_v = c.cold_en && (c.code < c.cold); // [RULE7] [RULE9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign c.hot_v  = r.hot_v;
   assign c.cold_v = r.cold_v;
   assign c.upd    = r.upd;

   property p_hot_cmp;
      @(posedge pclk) disable iff (!presetn)
      c.stb |=> (c.hot_v == $past(c.hot_en && (c.code > c.hot)));
   endproperty
   a_hot_cmp: assert property (p_hot_cmp) else $error("hot verdict wrong"); // [RULE7]
endmodule // atsm_cmp

// ### atsm_monitor.sv
// APB register block sequencing aux, self-test and alarm logic
//
// Register access over APB was chosen for this implementation.
`include "atsm_defines.svh"
module atsm_monitor (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        adc_done,
   input  wire logic [11:0] adc_code,
   input  wire logic        ref_osc,
   output logic             adc_start,
   output logic      [1:0]  adc_sel,
   output logic             pump_on,
   output logic             therm_bias_on,
   output logic             alarm_output_low,
   output logic             scan_busy
);
   typedef struct packed {
      atsm_pkg::atsm_state_e st;
      logic [15:0] status_flags;
      logic [15:0] converter_config;
      logic [15:0] acq_cfg;
      logic [15:0] cold_threshold;
      logic [15:0] hot_threshold;
      logic [15:0] aux_one_result;
      logic [15:0] aux_two_result;
      logic [15:0] selftest_result;
      logic [15:0] fault_analysis;
      logic [15:0] cnt;
      logic [5:0]  steps;
      logic        conv_wait;
      logic        ref_q;
      logic [3:0]  ref_tog;
      logic [1:0]  stb;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        adc_start;
      logic [1:0]  adc_sel;
      logic        pump_on;
      logic        therm_bias_on;
      logic        alarm_output_low;
      logic        busy;
   } atsm_mon_s;
   atsm_mon_s r, next_r;

   atsm_cmp_if ch1 ();
   atsm_cmp_if ch2 ();
   atsm_cmp u_cmp1 (.pclk(pclk), .presetn(presetn), .c(ch1));
   atsm_cmp u_cmp2 (.pclk(pclk), .presetn(presetn), .c(ch2));

   // Both compares see the same thresholds; enables come from each result register
   assign ch1.stb     = r.stb[0];
   assign ch1.code    = r.aux_one_result[11:0];
   assign ch1.cold    = r.cold_threshold[11:0];
   assign ch1.hot     = r.hot_threshold[11:0];
   assign ch1.hot_en  = r.aux_one_result[`ATSM_RES_HOT_COMPARE_ENABLE];  // [RULE9]
   assign ch1.cold_en = r.aux_one_result[`ATSM_RES_COLD_COMPARE_ENABLE]; // [RULE9]
   assign ch2.stb     = r.stb[1];
   assign ch2.code    = r.aux_two_result[11:0];
   assign ch2.cold    = r.cold_threshold[11:0];
   assign ch2.hot     = r.hot_threshold[11:0];
   assign ch2.hot_en  = r.aux_two_result[`ATSM_RES_HOT_COMPARE_ENABLE];
   assign ch2.cold_en = r.aux_two_result[`ATSM_RES_COLD_COMPARE_ENABLE];

   logic        acc;
   logic        wr;
   logic [7:0]  widx;
   logic        mapped;
   logic [15:0] rd;
   logic [15:0] settle_cyc;
   logic        hot_any;
   logic        cold_any;

   // Index from word address; upper address bits must be zero
   assign acc  = psel && penable && !r.pready;
   // Writes land on the edge where the master sees pready, not one edge early
   assign wr   = psel && penable && r.pready && pwrite;
   assign widx = paddr[9:2];
   assign settle_cyc = 16'(`ATSM_STEP_CYC) * {10'h000, r.acq_cfg[5:0]} + 16'(`ATSM_STEP_CYC); // [RULE22]
   assign hot_any  = (ch1.hot_v || ch2.hot_v);  // [RULE23]
   assign cold_any = (ch1.cold_v || ch2.cold_v); // [RULE23]

   // Read mux over the mapped words
   always_comb begin
      mapped = 1'b1;
      rd     = 16'h0000;
      unique case (widx)
         `ATSM_ADDR_STATUS:   rd = r.status_flags;
         `ATSM_ADDR_CONVCFG:  rd = r.converter_config;
         `ATSM_ADDR_ACQUISITION_CONFIG_REG:   rd = r.acq_cfg;
         `ATSM_ADDR_SCAN_CONTROL_REG: rd = {15'h0000, scan_busy};
         `ATSM_ADDR_FAULT:    rd = r.fault_analysis;
         `ATSM_ADDR_COLD:     rd = r.cold_threshold;
         `ATSM_ADDR_HOT:      rd = r.hot_threshold;
         `ATSM_ADDR_AUX1:     rd = r.aux_one_result;
         `ATSM_ADDR_AUX2:     rd = r.aux_two_result;
         `ATSM_ADDR_SELFTEST: rd = r.selftest_result;
         default:             mapped = 1'b0;
      endcase
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end
   end

   // Next-state: bus, sequencer, flags, alarm
   always_comb begin
      next_r = r;
      next_r.pready    = acc;
      next_r.pslverr   = acc && !mapped;
      next_r.prdata    = (acc && !pwrite) ? {16'h0000, rd} : 32'h00000000;
      next_r.adc_start = 1'b0;
      next_r.stb       = 2'b00;
      if (r.cnt != 16'h0000) begin
         next_r.cnt = r.cnt - 16'h0001;
      end

      // Register writes; results keep their code, only the enables are writable
      if (wr && mapped) begin
         unique case (widx)
            `ATSM_ADDR_CONVCFG: next_r.converter_config = {11'h000, pwdata[4:0]};
            `ATSM_ADDR_ACQUISITION_CONFIG_REG:  next_r.acq_cfg = {10'h000, pwdata[5:0]};
            `ATSM_ADDR_COLD:    next_r.cold_threshold = {4'h0, pwdata[11:0]};
            `ATSM_ADDR_HOT:     next_r.hot_threshold = {4'h0, pwdata[11:0]};
            `ATSM_ADDR_AUX1:    next_r.aux_one_result[15:14] = pwdata[15:14];
            `ATSM_ADDR_AUX2:    next_r.aux_two_result[15:14] = pwdata[15:14];
            // Write 0 clears a reference-open flag; a new detection in the same cycle wins
            `ATSM_ADDR_FAULT:   next_r.fault_analysis[`ATSM_FLT_REFOPEN] =
                                   r.fault_analysis[`ATSM_FLT_REFOPEN] & pwdata[`ATSM_FLT_REFOPEN];
            default: ;
         endcase
      end

      // Scan sequencer
      unique case (r.st)
         atsm_pkg::ATSM_IDLE: begin
            next_r.pump_on = 1'b1;
            next_r.therm_bias_on = 1'b0;
            if (wr && widx == `ATSM_ADDR_SCAN_CONTROL_REG && pwdata[0] && paddr[11:10] == 2'h0) begin
               next_r.st = atsm_pkg::ATSM_PWRUP;
               next_r.cnt = {8'h00, `ATSM_PWRUP_CYC};
               next_r.pump_on = 1'b0; // [RULE1]
               next_r.therm_bias_on = r.converter_config[`ATSM_CFG_AUX1EN]
                                   || r.converter_config[`ATSM_CFG_AUX2EN]; // [RULE21]
            end
         end
         atsm_pkg::ATSM_PWRUP: begin
            if (r.cnt == 16'h0000) begin
               next_r.st = atsm_pkg::ATSM_CELLS;
               next_r.cnt = {8'h00, `ATSM_CELL_CYC};
            end
         end
         atsm_pkg::ATSM_CELLS: begin
            // Cell scanning lives elsewhere; only its duration is modelled
            if (r.cnt == 16'h0000) begin
               if (r.converter_config[`ATSM_CFG_STEN]) begin // [RULE12] [RULE13]
                  next_r.st = atsm_pkg::ATSM_SELF;
                  next_r.adc_start = 1'b1;
                  next_r.adc_sel = 2'h3;
               end else if (r.converter_config[`ATSM_CFG_AUX1EN]) begin
                  next_r.st = atsm_pkg::ATSM_SET1;
                  next_r.cnt = settle_cyc;
               end else if (r.converter_config[`ATSM_CFG_AUX2EN]) begin
                  next_r.st = atsm_pkg::ATSM_SET2;
                  next_r.cnt = settle_cyc;
               end else begin
                  next_r.st = atsm_pkg::ATSM_IDLE;
               end
            end
         end
         atsm_pkg::ATSM_SELF: begin
            if (adc_done) begin
               next_r.selftest_result = {adc_code, 4'h0}; // [RULE12] [RULE14]
               if (r.converter_config[`ATSM_CFG_AUX1EN]) begin // [RULE3]
                  next_r.st = atsm_pkg::ATSM_SET1;
                  next_r.cnt = settle_cyc;
               end else if (r.converter_config[`ATSM_CFG_AUX2EN]) begin
                  next_r.st = atsm_pkg::ATSM_SET2;
                  next_r.cnt = settle_cyc;
               end else begin
                  next_r.st = atsm_pkg::ATSM_IDLE;
               end
            end
         end
         atsm_pkg::ATSM_SET1: begin
            if (r.cnt == 16'h0000) begin
               next_r.st = atsm_pkg::ATSM_CONV1;
               next_r.adc_start = 1'b1;
               next_r.adc_sel = 2'h1;
               next_r.cnt = {8'h00, `ATSM_CONV_CYC};
            end
         end
         atsm_pkg::ATSM_CONV1: begin
            // Conversion is bounded so the aux phase meets its time budget
            if (adc_done || r.cnt == 16'h0000) begin // [RULE6]
               next_r.aux_one_result[11:0] = adc_code; // [RULE4] [RULE5]
               next_r.stb[0] = 1'b1;
               if (r.converter_config[`ATSM_CFG_AUX2EN]) begin // [RULE19]
                  next_r.st = atsm_pkg::ATSM_SET2;
                  next_r.cnt = settle_cyc;
               end else begin
                  next_r.st = atsm_pkg::ATSM_IDLE;
               end
            end
         end
         atsm_pkg::ATSM_SET2: begin
            if (r.cnt == 16'h0000) begin
               next_r.st = atsm_pkg::ATSM_CONV2;
               next_r.adc_start = 1'b1;
               next_r.adc_sel = 2'h2;
               next_r.cnt = {8'h00, `ATSM_CONV_CYC};
            end
         end
         atsm_pkg::ATSM_CONV2: begin
            if (adc_done || r.cnt == 16'h0000) begin // [RULE6]
               next_r.aux_two_result[11:0] = adc_code; // [RULE4] [RULE5]
               next_r.stb[1] = 1'b1;
               next_r.st = atsm_pkg::ATSM_IDLE;
            end
         end
         default: next_r.st = atsm_pkg::ATSM_IDLE;
      endcase

      // Flags follow the latest verdicts, set and clear by hardware only
      if (ch1.upd || ch2.upd) begin
         next_r.status_flags[`ATSM_ST_HOT]  = hot_any;  // [RULE8] [RULE10]
         next_r.status_flags[`ATSM_ST_COLD] = cold_any; // [RULE8] [RULE10]
      end

      // Reference oscillation: count edges, flag after enough toggles
      next_r.ref_q = ref_osc;
      if (ref_osc != r.ref_q && r.ref_tog != `ATSM_REF_TOGGLES) begin
         next_r.ref_tog = r.ref_tog + 4'h1;
      end
      if (r.ref_tog == `ATSM_REF_TOGGLES) begin
         next_r.fault_analysis[`ATSM_FLT_REFOPEN] = 1'b1; // [RULE18]
         next_r.ref_tog = 4'h0;
      end

      // Alarm pin low while a routed flag is set
      next_r.alarm_output_low = !((next_r.status_flags[`ATSM_ST_HOT] && r.converter_config[`ATSM_CFG_OTEN])
                              || (next_r.status_flags[`ATSM_ST_COLD] && r.converter_config[`ATSM_CFG_UTEN])); // [RULE11] [RULE24]
      next_r.busy = (next_r.st != atsm_pkg::ATSM_IDLE);
   end

   // State register; pump runs and alarm idles high out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= atsm_pkg::ATSM_IDLE;
         r.status_flags <= `ATSM_STATUS_RST;
         r.pump_on <= 1'b1;
         r.alarm_output_low <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata           = r.prdata;
   assign pready           = r.pready;
   assign pslverr          = r.pslverr;
   assign adc_start        = r.adc_start;
   assign adc_sel          = r.adc_sel;
   assign pump_on          = r.pump_on;
   assign therm_bias_on    = r.therm_bias_on;
   assign alarm_output_low = r.alarm_output_low;
   assign scan_busy        = r.busy;

   property p_pump_off;
      @(posedge pclk) disable iff (!presetn)
      (r.st != atsm_pkg::ATSM_IDLE) |-> !pump_on;
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump on during scan"); // [RULE1]

   property p_self_first;
      @(posedge pclk) disable iff (!presetn)
      (r.st == atsm_pkg::ATSM_CELLS && r.cnt == 16'h0000 && r.converter_config[`ATSM_CFG_STEN])
         |=> (r.st == atsm_pkg::ATSM_SELF);
   endproperty
   a_self_first: assert property (p_self_first) else $error("self-test not after cells"); // [RULE13]

   property p_aux_order;
      @(posedge pclk) disable iff (!presetn)
      (r.st == atsm_pkg::ATSM_CONV2) |-> $past(r.st) inside {atsm_pkg::ATSM_SET2, atsm_pkg::ATSM_CONV2};
   endproperty
   a_aux_order: assert property (p_aux_order) else $error("aux two out of order"); // [RULE3]

   property p_bias;
      @(posedge pclk) disable iff (!presetn)
      ($past(r.st) == atsm_pkg::ATSM_IDLE && r.st == atsm_pkg::ATSM_PWRUP
       && (r.converter_config[`ATSM_CFG_AUX1EN] || r.converter_config[`ATSM_CFG_AUX2EN])) |-> therm_bias_on;
   endproperty
   a_bias: assert property (p_bias) else $error("bias not on at scan start"); // [RULE21]

   property p_conv_bound;
      @(posedge pclk) disable iff (!presetn)
      $rose(r.st == atsm_pkg::ATSM_CONV1) |-> ##[1:42] (r.st != atsm_pkg::ATSM_CONV1);
   endproperty
   a_conv_bound: assert property (p_conv_bound) else $error("aux conversion overran"); // [RULE6]

   property p_alarm;
      @(posedge pclk) disable iff (!presetn)
      (r.status_flags[`ATSM_ST_HOT] && r.converter_config[`ATSM_CFG_OTEN]
       && $stable(r.status_flags) && $stable(r.converter_config)) |-> !alarm_output_low;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm not asserted"); // [RULE11]

   property p_alarm_hold;
      @(posedge pclk) disable iff (!presetn)
      (r.status_flags[1:0] == 2'b00 && $stable(r.status_flags)) |-> alarm_output_low;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm without flag"); // [RULE24]

   property p_flag_follow;
      @(posedge pclk) disable iff (!presetn)
      ch1.upd && !ch2.upd |=> (r.status_flags[`ATSM_ST_HOT] == $past(hot_any));
   endproperty
   a_flag_follow: assert property (p_flag_follow) else $error("hot flag not updated"); // [RULE8] [RULE10]

   property p_self_nib;
      @(posedge pclk) disable iff (!presetn)
      r.selftest_result[3:0] == 4'h0;
   endproperty
   a_self_nib: assert property (p_self_nib) else $error("self-test low nibble set"); // [RULE14]

   c_scan:  cover property (@(posedge pclk) disable iff (!presetn) r.st == atsm_pkg::ATSM_CONV2);
   c_self:  cover property (@(posedge pclk) disable iff (!presetn) r.st == atsm_pkg::ATSM_SELF);
   c_alarm: cover property (@(posedge pclk) disable iff (!presetn) $fell(alarm_output_low));
   c_ref:   cover property (@(posedge pclk) disable iff (!presetn) r.fault_analysis[0]);
endmodule // atsm_monitor

// ### atsm_adc_model.sv
// Converter model standing on the far side of the start/done handshake
module atsm_adc_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        adc_start,
   input  wire logic [1:0]  adc_sel,
   input  wire logic [11:0] code_one,
   input  wire logic [11:0] code_two,
   input  wire logic [11:0] code_st,
   input  wire logic [3:0]  lat,
   output logic             adc_done,
   output logic      [11:0] adc_code
);
   timeunit 1ns;
   timeprecision 100ps;
   int         cnt;
   logic [1:0] sel;

   // One conversion at a time; latency set by the bench, from prompt to slow
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 0;
         sel      <= 2'h0;
         adc_done <= 1'b0;
         adc_code <= 12'h000;
      end else begin
         adc_done <= 1'b0;
         adc_code <= ~adc_code; // Stale code flips, so a late sample is caught
         if (adc_start) begin
            cnt <= int'(lat);
            sel <= adc_sel;
         end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_code <= (sel == 2'h1) ? code_one : (sel == 2'h2) ? code_two : code_st;
            cnt      <= 0;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule // atsm_adc_model

// ### test_aux_temp_selftest_monitor.sv
// Self-checking bench for the aux temperature and self-test monitor
`include "atsm_defines.svh"
module test_aux_temp_selftest_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ref_osc = 1'b0;
   logic [11:0] paddr = 12'h000, code_one = 12'h000, code_two = 12'h000, code_st = 12'h000;
   logic [31:0] pwdata = 32'h0, rdat, rnd = 32'h4b4d;
   logic [3:0]  lat = 4'h1;
   logic        rerr, adc_done, adc_start, pump_on, therm_bias_on, alarm_output_low, scan_busy, pready, pslverr;
   logic [31:0] prdata;
   logic [11:0] adc_code, m1, m2;
   logic [1:0]  adc_sel, e1, e2;
   logic [4:0]  cfg;
   logic [15:0] mst;
   logic        vh1, vh2, vc1, vc2, aux_any;
   int          n_fail, compares, cyc, last_done, scan_cyc, t_aux0, viol, n, lim;
   logic [1:0]  seq[$], exq[$];
   logic [7:0]  rv [9] = '{8'h02, 8'h08, 8'h0c, 8'h0e, 8'h1e, 8'h1f, 8'h40, 8'h41, 8'h42};

   atsm_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_done(adc_done), .adc_code(adc_code), .ref_osc(ref_osc), .adc_start(adc_start),
      .adc_sel(adc_sel), .pump_on(pump_on), .therm_bias_on(therm_bias_on),
      .alarm_output_low(alarm_output_low), .scan_busy(scan_busy));
   atsm_adc_model adc (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_sel(adc_sel),
      .code_one(code_one), .code_two(code_two), .code_st(code_st), .lat(lat), .adc_done(adc_done),
      .adc_code(adc_code));

   // 20 MHz clock
   always #25 pclk = ~pclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00}; // Registers are word indexed
   endfunction

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // APB master: holds the request until pready, then lets one edge pass
   task automatic apb(input logic wr, input logic [7:0] i, input logic [31:0] d);
      int k;
      k = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= ba(i);
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdat    = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic complete_run;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watch of converter starts, settle gaps and scan-time levels
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (adc_done === 1'b1) last_done <= cyc;
      if (adc_done === 1'b1 && adc_sel === 2'h3) t_aux0 <= cyc;
      if (adc_start === 1'b1) begin
         seq.push_back(adc_sel);
         if (cyc - scan_cyc < 79) viol++;
         if (adc_sel !== 2'h3 && cyc - last_done < 105) viol++;
      end
      if (scan_busy === 1'b1 && (pump_on !== 1'b0 || (aux_any && therm_bias_on !== 1'b1))) viol++;
   end

   // Hang guard
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      complete_run();
   end

   initial begin
      {vh1, vh2, vc1, vc2, aux_any} = 5'h0;
      {m1, m2, mst} = 40'h0;
      repeat (16) @(posedge pclk);
      chk({pump_on, alarm_output_low, therm_bias_on, scan_busy}, 4'hc);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, then access kinds and refusals
      foreach (rv[k]) begin
         apb(1'b0, rv[k], 32'h0);
         chk({rerr, rdat}, 33'h0);
      end
      apb(1'b1, `ATSM_ADDR_CONVCFG, 32'hffff_ffe0);
      apb(1'b0, `ATSM_ADDR_CONVCFG, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, `ATSM_ADDR_AUX1, 32'h0000_ffff);
      apb(1'b0, `ATSM_ADDR_AUX1, 32'h0);
      chk(rdat, 32'h0000_c000);
      apb(1'b1, `ATSM_ADDR_SELFTEST, 32'h0000_ffff);
      apb(1'b0, `ATSM_ADDR_SELFTEST, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 8'h03, 32'h0);
      chk({rerr, rdat}, 33'h1_0000_0000);
      apb(1'b1, `ATSM_ADDR_COLD, 32'h0000_0400);
      apb(1'b1, `ATSM_ADDR_HOT, 32'h0000_0c00);
      apb(1'b0, `ATSM_ADDR_HOT, 32'h0);
      chk(rdat, 32'h0000_0c00);
      apb(1'b1, `ATSM_ADDR_ACQUISITION_CONFIG_REG, 32'h0); // Shortest settle keeps the upper supply up
      // Eight scans walk every self-test and aux enable mix with random codes, latencies, alarm and compare enables
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         cfg = {i[2], rnd[3:2], i[1:0]};
         {e1, e2} = rnd[7:4];
         code_one <= rnd[27:16];
         lat      <= {1'b0, rnd[30:28]} + 4'h1;
         rnd = lfsr(rnd);
         code_two <= rnd[11:0];
         code_st  <= rnd[27:16];
         apb(1'b1, `ATSM_ADDR_AUX1, {16'h0, e1, 14'h0});
         apb(1'b1, `ATSM_ADDR_AUX2, {16'h0, e2, 14'h0});
         apb(1'b1, `ATSM_ADDR_CONVCFG, {27'h0, cfg});
         aux_any = cfg[0] | cfg[1];
         exq.delete();
         if (cfg[4]) exq.push_back(2'h3);
         if (cfg[0]) exq.push_back(2'h1);
         if (cfg[1]) exq.push_back(2'h2);
         seq.delete();
         viol = 0;
         apb(1'b1, `ATSM_ADDR_SCAN_CONTROL_REG, 32'h1);
         scan_cyc  = cyc - 1;
         last_done = cyc;
         t_aux0    = scan_cyc + 81;
         if (i == 0) begin
            apb(1'b0, `ATSM_ADDR_SCAN_CONTROL_REG, 32'h0);
            chk(rdat[0], 1'b1);
            apb(1'b1, `ATSM_ADDR_SCAN_CONTROL_REG, 32'h1); // Refused while busy
         end
         n = 0;
         while (scan_busy !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
         end
         lim = (cfg[1:0] == 2'h3) ? 340 : 200;
         if (aux_any) chk(cyc - t_aux0 <= lim, 1'b1);
         repeat (3) @(posedge pclk);
         chk(viol, 0);
         chk(seq.size(), exq.size());
         foreach (exq[k]) chk(seq[k], exq[k]);
         if (cfg[0]) begin
            m1  = code_one;
            vh1 = e1[1] && code_one > 12'hc00;
            vc1 = e1[0] && code_one < 12'h400;
         end
         if (cfg[1]) begin
            m2  = code_two;
            vh2 = e2[1] && code_two > 12'hc00;
            vc2 = e2[0] && code_two < 12'h400;
         end
         if (cfg[4]) mst = {code_st, 4'h0};
         apb(1'b0, `ATSM_ADDR_AUX1, 32'h0);
         chk(rdat, {16'h0, e1, 2'b00, m1});
         apb(1'b0, `ATSM_ADDR_AUX2, 32'h0);
         chk(rdat, {16'h0, e2, 2'b00, m2});
         apb(1'b0, `ATSM_ADDR_SELFTEST, 32'h0);
         chk(rdat, {16'h0, mst});
         apb(1'b1, `ATSM_ADDR_STATUS, 32'h0);
         apb(1'b0, `ATSM_ADDR_STATUS, 32'h0);
         chk(rdat, {30'h0, vh1 | vh2, vc1 | vc2});
         chk(alarm_output_low, !(((vh1 | vh2) & cfg[2]) | ((vc1 | vc2) & cfg[3])));
      end
      // Reference-pin watcher: seven toggles stay quiet, the eighth flags
      for (int t = 1; t <= 8; t++) begin
         ref_osc <= ~ref_osc;
         repeat (2) @(posedge pclk);
         if (t >= 7) begin
            repeat (2) @(posedge pclk);
            apb(1'b0, `ATSM_ADDR_FAULT, 32'h0);
            chk(rdat[0], t == 8);
         end
      end
      apb(1'b1, `ATSM_ADDR_FAULT, 32'h0);
      apb(1'b0, `ATSM_ADDR_FAULT, 32'h0);
      chk(rdat[0], 1'b0);
      complete_run();
   end
endmodule // test_aux_temp_selftest_monitor
